// ---- hw/asq_top.sv ----
// sequence trigger, priority, averaging and sequencer 0 input select.
// assumes an Avalon-MM master and a converter core on clk_sys.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "asq_map.svh"
module asq_top (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic [7:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    output logic                        convStart,
    output logic [1:0]                  convChannel,
    input  wire logic                   convDone,
    input  wire logic [`ASQ_DATA_W-1:0] convData,
    input  wire logic [5:0]             otherSelect,
    output logic                        resultValid,
    output logic [`ASQ_DATA_W-1:0]      resultData,
    output logic [1:0]                  resultSeq,
    output logic [2:0]                  resultStep,
    output logic                        seqBusy
);
    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [1:0] fld2(input logic [31:0] r,
                                        input logic [2:0]  n);
        return r[4*n +: 2];
    endfunction

    // sequencers 1..3 take their channel from the shared side input
    function automatic logic [1:0] chanFor(input logic [1:0]  sq,
                                           input logic [2:0]  st,
                                           input logic [31:0] mx,
                                           input logic [5:0]  oth);
        return (sq == 2'h0) ? fld2(mx, st) : oth[2*(sq-2'h1) +: 2];
    endfunction

    function automatic logic [31:0] wrMerge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be,
                                            input logic [31:0] msk);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & msk;
        return (old & ~m) | (wd & m);
    endfunction

    // lowest priority value wins; ties fall to the lower index
    function automatic logic [1:0] pickSeq(input logic [3:0]  pend,
                                           input logic [31:0] pri);
        logic [1:0] best;
        logic [1:0] bestPri;
        logic       have;
        best    = 2'h0;
        bestPri = 2'h3;
        have    = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (pend[i] && (!have || fld2(pri, 3'(i)) < bestPri)) begin
                best    = 2'(i);
                bestPri = fld2(pri, 3'(i));
                have    = 1'b1;
            end
        end
        return best;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // registers and bus
    logic [31:0]           activeQ;
    logic [31:0]           prioQ;
    logic [31:0]           avgQ;
    logic [31:0]           muxQ;
    logic [31:0]           endQ;
    logic [3:0]            pendQ;
    logic [3:0]            pendD;
    logic [3:0]            trigMask;
    logic [3:0]            launchMask;
    logic                  ackQ;
    logic                  busReq;
    logic                  wrTake;
    asq_pkg::asq_state_e   stateQ;
    asq_pkg::asq_sel_t     curSeqQ;
    asq_pkg::asq_sel_t     pickSel;
    asq_pkg::asq_step_t    stepQ;
    logic [2:0]            avgExpQ;
    logic                  launch;
    logic                  lastStep;
    logic                  avgValid;
    logic [`ASQ_DATA_W-1:0] avgData;

    // one wait cycle per access, taken at the second edge
    assign busReq          = avs_read || avs_write;
    assign avs_waitrequest = busReq && !ackQ;
    assign wrTake          = avs_write && ackQ;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ackQ <= 1'b0;
        end else begin
            ackQ <= busReq && !ackQ;
        end
    end

    // reserved bits and the initiate register read as zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ackQ) begin
            case (avs_address)
                `ASQ_OFF_ACTIVE: avs_readdata <= activeQ;
                `ASQ_OFF_STATUS: avs_readdata <= {23'h0, seqBusy,
                                                  pendQ, 2'h0, curSeqQ};
                `ASQ_OFF_PRIO:   avs_readdata <= prioQ;
                `ASQ_OFF_AVG:    avs_readdata <= avgQ; // R12
                `ASQ_OFF_INPUT_SELECT_STEP_0:   avs_readdata <= muxQ; // R12
                `ASQ_OFF_END0:   avs_readdata <= endQ;
                default:         avs_readdata <= 32'h0000_0000; // R5
            endcase
        end
    end

    // masks keep reserved bits at zero whatever software writes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            activeQ <= `ASQ_RST_ACTIVE;
            prioQ   <= `ASQ_RST_PRIO;
            avgQ    <= `ASQ_RST_AVG;
            muxQ    <= `ASQ_RST_INPUT_SELECT_STEP_0;
            endQ    <= `ASQ_RST_END0;
        end else if (wrTake) begin
            case (avs_address)
                `ASQ_OFF_ACTIVE: activeQ <= wrMerge(activeQ, avs_writedata,
                                     avs_byteenable, `ASQ_MASK_ACTIVE);
                `ASQ_OFF_PRIO:   prioQ <= wrMerge(prioQ, avs_writedata,
                                     avs_byteenable, `ASQ_MASK_PRIO);
                `ASQ_OFF_AVG:    avgQ <= wrMerge(avgQ, avs_writedata,
                                     avs_byteenable, `ASQ_MASK_AVG); // R12
                `ASQ_OFF_INPUT_SELECT_STEP_0:   muxQ <= wrMerge(muxQ, avs_writedata,
                                     avs_byteenable, `ASQ_MASK_INPUT_SELECT_STEP_0); // R10
                `ASQ_OFF_END0:   endQ <= wrMerge(endQ, avs_writedata,
                                     avs_byteenable, `ASQ_MASK_END0);
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // trigger and arbitration
    // any subset of the four bits in one write, gated by enables
    assign trigMask = (wrTake && avs_address == `ASQ_OFF_INIT
                       && avs_byteenable[0])
                    ? (avs_writedata[3:0] & activeQ[3:0]) : 4'h0; // R1 R2 R3
    assign launch     = (stateQ == asq_pkg::ST_IDLE) && (|pendQ);
    assign pickSel    = pickSeq(pendQ, prioQ); // R4 R13
    assign launchMask = launch ? (4'h1 << pickSel) : 4'h0;
    // a trigger landing on the launch cycle wins over the clear
    assign pendD      = ((pendQ & ~launchMask) & activeQ[3:0]) | trigMask;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pendQ <= 4'h0;
        end else begin
            pendQ <= pendD; // R3
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequence engine
    // sequencers 1..3 run one step from otherSelect
    assign lastStep = (curSeqQ != 2'h0) || (stepQ == `ASQ_LAST_STEP)
                   || endQ[4*stepQ + `ASQ_END_BIT]; // R14
    assign convStart = (stateQ == asq_pkg::ST_START);
    assign seqBusy   = (stateQ != asq_pkg::ST_IDLE);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stateQ <= asq_pkg::ST_IDLE;
        end else begin
            case (stateQ)
                asq_pkg::ST_IDLE: begin
                    if (launch) begin
                        stateQ <= asq_pkg::ST_START;
                    end
                end
                asq_pkg::ST_START: begin
                    stateQ <= asq_pkg::ST_WAIT;
                end
                asq_pkg::ST_WAIT: begin
                    if (convDone) begin
                        stateQ <= asq_pkg::ST_STEP;
                    end
                end
                asq_pkg::ST_STEP: begin
                    if (!avgValid) begin
                        stateQ <= asq_pkg::ST_START;
                    end else if (lastStep) begin
                        stateQ <= asq_pkg::ST_IDLE; // R14
                    end else begin
                        stateQ <= asq_pkg::ST_START;
                    end
                end
                default: begin
                    stateQ <= asq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // exponent held per sequence so a mid-run write cannot split a sum
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            curSeqQ <= 2'h0;
            stepQ   <= 3'h0;
            avgExpQ <= 3'h0;
        end else if (launch) begin
            curSeqQ <= pickSel;
            stepQ   <= 3'h0;
            avgExpQ <= avgQ[2:0]; // R6 R9
        end else if (stateQ == asq_pkg::ST_STEP && avgValid && !lastStep) begin
            stepQ <= stepQ + 3'h1;
        end
    end

    // loaded with the next step so it already stands at the start pulse
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            convChannel <= 2'h0;
        end else if (launch) begin
            convChannel <= chanFor(pickSel, 3'h0, muxQ, otherSelect); // R11
        end else if (stateQ == asq_pkg::ST_STEP && avgValid && !lastStep) begin
            convChannel <= chanFor(curSeqQ, stepQ + 3'h1, muxQ,
                                   otherSelect); // R10 R11
        end
    end

    asq_avg u_avg (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .clear    (stateQ == asq_pkg::ST_IDLE),
        .inValid  (stateQ == asq_pkg::ST_WAIT && convDone),
        .inData   (convData),
        .expo     (avgExpQ),
        .outValid (avgValid),
        .outData  (avgData)
    );

    assign resultValid = avgValid;
    assign resultData  = avgData;
    assign resultSeq   = curSeqQ;
    assign resultStep  = stepQ;

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic [`ASQ_CNT_W:0] convCnt;
    logic                prioBad;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            convCnt <= '0;
        end else if (avgValid || stateQ == asq_pkg::ST_IDLE) begin
            convCnt <= '0;
        end else if (stateQ == asq_pkg::ST_WAIT && convDone) begin
            convCnt <= convCnt + 9'h001;
        end
    end

    always_comb begin
        prioBad = 1'b0;
        for (int j = 0; j < 4; j++) begin
            if (pendQ[j] && fld2(prioQ, 3'(j)) < fld2(prioQ, 3'(pickSel))) begin
                prioBad = 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_TRIG_SETS: assert property ( // R1
        wrTake && avs_address == `ASQ_OFF_INIT && avs_byteenable[0]
        |=> ((pendQ & $past(avs_writedata[3:0] & activeQ[3:0]))
             == $past(avs_writedata[3:0] & activeQ[3:0])))
        else $error("triggered sequencer not pending");
    AST_DISABLED_IGNORED: assert property ( // R2
        (pendQ & ~$past(pendQ) & ~$past(activeQ[3:0])) == 4'h0)
        else $error("disabled sequencer became pending");
    AST_MULTI_ORDER: assert property ( // R4
        launch |-> !prioBad)
        else $error("lower priority sequencer launched first");
    AST_INIT_READ_ZERO: assert property ( // R5
        avs_read && ackQ && avs_address == `ASQ_OFF_INIT
        |-> avs_readdata == 32'h0000_0000)
        else $error("initiate read not zero");
    AST_AVG_RSV: assert property ( // R12
        avs_read && ackQ && avs_address == `ASQ_OFF_AVG
        |-> avs_readdata[31:3] == 29'h0)
        else $error("averaging reserved bits not zero");
    AST_PASS_THROUGH: assert property ( // R7
        stateQ == asq_pkg::ST_WAIT && convDone && avgExpQ == 3'h0
        |=> resultValid && resultData == $past(convData))
        else $error("exponent zero result not raw sample");
    AST_AVG_64: assert property ( // R8
        resultValid && avgExpQ == 3'h6 |-> convCnt == 9'h040)
        else $error("exponent six did not use 64 samples");
    AST_AVG_COUNT: assert property ( // R6
        resultValid |-> convCnt == (9'h001 << avgExpQ))
        else $error("result sample count wrong");
    AST_END_STOP: assert property ( // R14
        stateQ == asq_pkg::ST_STEP && avgValid && lastStep
        |=> stateQ == asq_pkg::ST_IDLE && stepQ == $past(stepQ))
        else $error("sequence ran past its end step");
    AST_CHANNEL: assert property ( // R10
        convStart && curSeqQ == 2'h0 |-> convChannel == fld2(muxQ, stepQ))
        else $error("wrong input channel for step");
    AST_START_PULSE: assert property ( // R11
        convStart |=> !convStart [*2])
        else $error("conversion start not a single pulse");

    COV_MULTI_TRIG: cover property (
        trigMask == 4'hF);
    COV_AVG64: cover property (
        resultValid && avgExpQ == 3'h6);
    COV_EARLY_END: cover property (
        stateQ == asq_pkg::ST_STEP && avgValid && curSeqQ == 2'h0
        && stepQ == 3'h2 && lastStep);
    COV_TRIG_ON_LAUNCH: cover property (
        launch && (trigMask & launchMask) != 4'h0);
endmodule

// ---- pkg/asq_map.svh ----
// register map, field layouts, reset values and widths of the sequence
// trigger, averaging and input-select block; definitions only.
// Contract
// R1: initiate bit n starts sequencer n
// R2: triggers to disabled sequencers are ignored
// R3: one write may trigger any combination
// R4: simultaneous triggers run in priority order
// R5: initiate register is write-only, reads meaningless
// R6: 3-bit exponent, average of 2^N conversions
// R7: exponent zero passes conversion unchanged
// R8: exponent six averages sixty-four conversions
// R9: software keeps exponent within zero to six
// R10: eight 2-bit selects, step n at 4n
// R11: select value names converted input channel
// R12: reserved bits read undefined, written back
// R13: priority zero highest, three lowest
// R14: sequence stops at first step ending
// R15: sum conversions, shift right by exponent
`ifndef ASQ_MAP_SVH
`define ASQ_MAP_SVH

`define ASQ_OFF_ACTIVE 8'h00
`define ASQ_OFF_STATUS 8'h04
`define ASQ_OFF_PRIO   8'h20
`define ASQ_OFF_INIT   8'h28
`define ASQ_OFF_AVG    8'h30
`define ASQ_OFF_INPUT_SELECT_STEP_0   8'h40
`define ASQ_OFF_END0   8'h44

`define ASQ_MASK_ACTIVE 32'h0000_000F
`define ASQ_MASK_PRIO   32'h0000_3333
`define ASQ_MASK_AVG    32'h0000_0007
`define ASQ_MASK_INPUT_SELECT_STEP_0   32'h3333_3333
`define ASQ_MASK_END0   32'h2222_2222

`define ASQ_RST_ACTIVE 32'h0000_0000
`define ASQ_RST_PRIO   32'h0000_3210
`define ASQ_RST_AVG    32'h0000_0000
`define ASQ_RST_INPUT_SELECT_STEP_0   32'h0000_0000
`define ASQ_RST_END0   32'h0000_0000

`define ASQ_END_BIT   1
`define ASQ_LAST_STEP 3'h7
`define ASQ_DATA_W    10
`define ASQ_SUM_W     17
`define ASQ_CNT_W     8

`endif

// ---- pkg/asq_pkg.sv ----
// types used by the sequence trigger block; its averager uses none of them.
// assumes asq_map.svh is compiled alongside.
package asq_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_WAIT  = 2'b10,
        ST_STEP  = 2'b11
    } asq_state_e;
    typedef logic [1:0] asq_sel_t;
    typedef logic [2:0] asq_step_t;
endpackage

// ---- hw/asq_avg.sv ----
// sample averager: accumulates 2^expo conversions, emits one result.
// assumes the caller holds expo steady and clears between sequences.
`timescale 1ns/1ps
`include "asq_map.svh"
module asq_avg (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic                   clear,
    input  wire logic                   inValid,
    input  wire logic [`ASQ_DATA_W-1:0] inData,
    input  wire logic [2:0]             expo,
    output logic                        outValid,
    output logic [`ASQ_DATA_W-1:0]      outData
);
    logic [`ASQ_SUM_W-1:0] sumQ;
    logic [`ASQ_SUM_W-1:0] sumD;
    logic [`ASQ_CNT_W-1:0] cntQ;
    logic [`ASQ_CNT_W-1:0] target;
    logic                  lastOne;

    // expo 7 gives 128 samples; the sum still fits, result stays bounded
    assign target  = `ASQ_CNT_W'(1) << expo; // R6 R8
    assign sumD    = sumQ + `ASQ_SUM_W'(inData); // R15
    assign lastOne = inValid && ((cntQ + `ASQ_CNT_W'(1)) == target);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sumQ <= `ASQ_SUM_W'(0);
            cntQ <= `ASQ_CNT_W'(0);
        end else if (clear || lastOne) begin
            sumQ <= `ASQ_SUM_W'(0);
            cntQ <= `ASQ_CNT_W'(0);
        end else if (inValid) begin
            sumQ <= sumD;
            cntQ <= cntQ + `ASQ_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            outValid <= 1'b0;
            outData  <= `ASQ_DATA_W'(0);
        end else begin
            outValid <= lastOne && !clear;
            if (lastOne) begin
                // exponent zero shifts by nothing: raw value passes
                outData <= `ASQ_DATA_W'(sumD >> expo); // R7 R15
            end
        end
    end
endmodule

// ---- verification/asq_conv_model.sv ----
// converter core model: one conversion per start pulse, slow or prompt.
// assumes start and channel come from asq_top on the same clock.
`timescale 1ns/1ps
`include "asq_map.svh"
module asq_conv_model (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic                   convStart,
    input  wire logic [1:0]             convChannel,
    input  wire logic [3:0]             latency,
    output logic                        convDone,
    output logic [`ASQ_DATA_W-1:0]      convData
);
////////////////////////////////////////////////////////////////////////
    logic       busy_q;
    logic [3:0] wait_q;
    logic [1:0] chan_q;
    logic [7:0] serial_q;

    // data carries the channel on top so a wrong select shows at once
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_q   <= 1'b0;
            wait_q   <= 4'h0;
            chan_q   <= 2'h0;
            serial_q <= 8'h00;
            convDone <= 1'b0;
            convData <= '0;
        end else begin
            convDone <= 1'b0;
            // between answers the data lines do not hold the last value
            convData <= ~convData;
            if (convStart) begin
                busy_q <= 1'b1;
                wait_q <= latency;
                chan_q <= convChannel;
            end else if (busy_q && wait_q == 4'h0) begin
                busy_q   <= 1'b0;
                convDone <= 1'b1;
                convData <= {chan_q, serial_q};
                serial_q <= serial_q + 8'h01;
            end else if (busy_q) begin
                wait_q <= wait_q - 4'h1;
            end
        end
    end
endmodule

// ---- verification/asq_top_tb.sv ----
// testbench: register access, trigger order, averaging, input select.
// assumes asq_top and the converter model share one clock.
`timescale 1ns/1ps
`include "asq_map.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value at %0t: got %0h exp %0h", $time, g, e); end end
module asq_top_tb;
    logic                   clk_sys;
    logic                   rst;
    logic [7:0]             avs_address;
    logic                   avs_read;
    logic                   avs_write;
    logic [31:0]            avs_writedata;
    logic [3:0]             avs_byteenable;
    logic [31:0]            avs_readdata;
    logic                   avs_waitrequest;
    logic                   convStart;
    logic [1:0]             convChannel;
    logic                   convDone;
    logic [`ASQ_DATA_W-1:0] convData;
    logic [5:0]             otherSelect;
    logic                   resultValid;
    logic [`ASQ_DATA_W-1:0] resultData;
    logic [1:0]             resultSeq;
    logic [2:0]             resultStep;
    logic                   seqBusy;
    logic [3:0]             latency;
    logic [31:0]            rd;
    int                     n_fail;
    int                     check_count;
    int                     i;
    int                     accSum;
    int                     accCnt;
    logic [1:0]             accChan;
    logic [`ASQ_DATA_W-1:0] rDataQ[$];
    logic [1:0]             rSeqQ[$];
    logic [2:0]             rStepQ[$];
    logic [1:0]             rChanQ[$];
    int                     rCntQ[$];
    int                     rSumQ[$];
    logic [1:0]             expChan[4] = '{2'h2, 2'h1, 2'h3, 2'h1};

    asq_top u_asq_top (
        .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .convStart(convStart), .convChannel(convChannel),
        .convDone(convDone), .convData(convData),
        .otherSelect(otherSelect), .resultValid(resultValid),
        .resultData(resultData), .resultSeq(resultSeq),
        .resultStep(resultStep), .seqBusy(seqBusy)
    );
    asq_conv_model u_asq_conv_model (
        .clk_sys(clk_sys), .rst(rst), .convStart(convStart),
        .convChannel(convChannel), .latency(latency),
        .convDone(convDone), .convData(convData)
    );

    always #2.5 clk_sys = ~clk_sys;
////////////////////////////////////////////////////////////////////////
    // sums what the converter really delivered, per result
    always @(posedge clk_sys) begin
        if (convDone === 1'b1) begin
            accSum = accSum + int'(convData);
            accCnt = accCnt + 1;
            accChan = convChannel;
        end
        if (resultValid === 1'b1) begin
            rDataQ.push_back(resultData);
            rSeqQ.push_back(resultSeq);
            rStepQ.push_back(resultStep);
            rChanQ.push_back(accChan);
            rCntQ.push_back(accCnt);
            rSumQ.push_back(accSum);
            accSum = 0;
            accCnt = 0;
        end
    end
////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic busAcc(input logic wr, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        if (k == 20) begin
            n_fail++;
            results();
        end
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        busAcc(1'b1, a, d, rd);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        busAcc(1'b0, a, 32'h0000_0000, rd);
        `CHK(rd, e)
    endtask

    task automatic clr();
        rDataQ.delete();
        rSeqQ.delete();
        rStepQ.delete();
        rChanQ.delete();
        rCntQ.delete();
        rSumQ.delete();
    endtask

    // the quiet tail catches steps run past the end flag
    task automatic waitRes(input int n);
        int k;
        for (k = 0; k < 4000 && rDataQ.size() < n; k++) @(posedge clk_sys);
        if (k == 4000) begin
            n_fail++;
            results();
        end
        repeat (30) @(posedge clk_sys);
        `CHK(rDataQ.size(), n)
    endtask

    task automatic checkRes(input int n, input logic [1:0] s,
                            input logic [2:0] st, input logic [1:0] ch,
                            input int a);
        `CHK(rSeqQ[n], s)
        `CHK(rStepQ[n], st)
        `CHK(rChanQ[n], ch)
        `CHK(rCntQ[n], 1 << a)
        `CHK(rDataQ[n], `ASQ_DATA_W'(rSumQ[n] >> a))
    endtask
////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        otherSelect = 6'h27;
        latency = 4'h1;
        n_fail = 0;
        check_count = 0;
        accSum = 0;
        accCnt = 0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        rdChk(8'h30, 32'h0000_0000);
        rdChk(8'h40, 32'h0000_0000);
        rdChk(8'h20, 32'h0000_3210);
        rdChk(8'h28, 32'h0000_0000);
        wr(8'h40, 32'hFFFF_FFFF);
        rdChk(8'h40, 32'h3333_3333);
        wr(8'h30, 32'hFFFF_FFFE);
        rdChk(8'h30, 32'h0000_0006);
        wr(8'h28, 32'h0000_000F);
        rdChk(8'h28, 32'h0000_0000);
        // sequencer 0 alone, three steps then the end flag
        wr(8'h00, 32'h0000_0001);
        wr(8'h30, 32'h0000_0000);
        wr(8'h40, 32'h0321_0321);
        wr(8'h44, 32'h0000_0200);
        clr();
        wr(8'h28, 32'h0000_0001);
        waitRes(3);
        for (i = 0; i < 3; i++) checkRes(i, 2'h0, 3'(i), 2'(i + 1), 0);
        // targets that are not enabled
        clr();
        wr(8'h28, 32'h0000_000E);
        waitRes(0);
        // all four at once, priorities reversed, slow converter
        wr(8'h00, 32'h0000_000F);
        wr(8'h20, 32'h0000_0123);
        wr(8'h44, 32'h0000_0002);
        latency <= 4'h6;
        clr();
        wr(8'h28, 32'h0000_000F);
        waitRes(4);
        for (i = 0; i < 4; i++) checkRes(i, 2'(3 - i), 3'h0, expChan[i], 0);
        rdChk(8'h44, 32'h0000_0002);
        // every legal exponent, prompt converter
        latency <= 4'h0;
        wr(8'h00, 32'h0000_0001);
        for (i = 0; i <= 6; i++) begin
            wr(8'h30, 32'(i));
            clr();
            wr(8'h28, 32'h0000_0001);
            waitRes(1);
            checkRes(0, 2'h0, 3'h0, 2'h1, i);
        end
        `CHK(seqBusy, 1'b0)
        rdChk(8'h04, 32'h0000_0000);
        rdChk(8'h00, 32'h0000_0001);
        results();
    end
endmodule
